// [core/external_memory_interface_pkg.sv]
// Purpose: Constants and carrier types for the external memory bus interface.
// Assumes: 16-bit data-space addresses, 8-bit data, internal SRAM ends below 0x1100.
// Notes: Control bits arrive as plain ports; no register bus.
package external_memory_interface_pkg;

    // ****************************************
    // Address map
    // ****************************************
    localparam logic [15:0] EXT_BASE = 16'h1100;
    localparam logic [15:0] SECTOR_STEP = 16'h2000;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int HIGH_ADDR_W = 8;
    localparam logic [2:0] SECTOR_LIMIT_RST = 3'h0;
    localparam logic [2:0] HIGH_MASK_SEL_RST = 3'h0;
    localparam logic [1:0] WAIT_NONE = 2'h0;
    localparam logic [1:0] WAIT_ONE = 2'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] ADDR_ZERO = 16'h0000;
    localparam logic [1:0] WAIT_CNT_RST = 2'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic ext_mem_enable;
        logic legacy_mode;
        logic legacy_wait_state_bit;
        logic [1:0] upper_wait_state_field;
        logic [1:0] lower_wait_state_field;
        logic [2:0] sector_limit_field;
        logic [2:0] high_mask_sel;
        logic bus_keeper_enable;
    } external_memory_interface_cfg_type;

    typedef struct packed {
        logic req;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } cpu_req_type;

    typedef struct packed {
        logic [7:0] port_out;
        logic [7:0] port_dir;
    } port_pins_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_STROBE = 3'b011,
        ST_WAIT = 3'b010,
        ST_END = 3'b110
    } bus_state_type;

endpackage

// [core/external_memory_interface_pin_sync.sv]
// Purpose: Three-flop synchroniser for the data bus inputs from the pins.
// Assumes: One clock domain, clk_sys.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ps
module external_memory_interface_pin_sync
    import external_memory_interface_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_sync
);

    logic [7:0] s1_q;
    logic [7:0] s2_q;
    logic [7:0] s3_q;
    logic [7:0] out_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_q <= BYTE_ZERO;
            s2_q <= BYTE_ZERO;
            s3_q <= BYTE_ZERO;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per bit, the output only follows when the last two stages agree.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            out_q <= BYTE_ZERO;
        end else begin
            out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
        end
    end

    assign pin_sync = out_q;

endmodule

// [core/ext_mem_bus_if.sv]
// Purpose: External memory bus interface between the CPU data port and the pins.
// Assumes: The CPU holds req, write, addr and wdata stable until done pulses.
// Notes: Read data returns through a three-flop synchroniser, so reads finish
//        a few cycles after the read strobe rises; see the timing notes below.
`timescale 1ns/1ps
module ext_mem_bus_if
    import external_memory_interface_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire external_memory_interface_cfg_type cfg,
    input wire cpu_req_type cpu_req,
    output logic cpu_done,
    output logic cpu_ext,
    output logic cpu_fault,
    output logic [7:0] cpu_rdata,
    input wire port_pins_type ad_port,
    input wire port_pins_type ha_port,
    input wire port_pins_type ctl_port,
    input wire logic [7:0] muxed_addr_data_bus_in,
    output logic [7:0] muxed_addr_data_bus_out,
    output logic [7:0] muxed_addr_data_bus_oe,
    output logic [7:0] high_address_bus_out,
    output logic [7:0] high_address_bus_oe,
    output logic ale_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic [2:0] ctl_oe,
    output logic [7:0] bus_keeper_en
);

    // ****************************************
    // Helper functions
    // ****************************************
    // Upper sector starts at limit * 0x2000; limit 0 means no lower sector.
    function automatic logic in_lower_sector(input logic [15:0] a, input logic [2:0] lim);
        logic [15:0] bound;
        bound = 16'(SECTOR_STEP * {13'd0, lim});
        in_lower_sector = (lim != SECTOR_LIMIT_RST) && (a < bound);
    endfunction

    // Mask selecting how many high address bits are released to the memory.
    function automatic logic [7:0] high_mask(input logic [2:0] sel);
        high_mask = 8'hFF >> sel;
    endfunction

    // ****************************************
    // Configuration after legacy filtering
    // ****************************************
    logic [1:0] wait_sel;
    logic [7:0] hmask;
    logic keeper_on;
    logic req_is_ext;
    logic external_memory_interface_on;

    assign external_memory_interface_on = cfg.ext_mem_enable;
    assign req_is_ext = cpu_req.addr >= EXT_BASE;

    always_comb begin
        if (cfg.legacy_mode) begin
            // Only zero or one wait state, one region, fixed width.
            wait_sel = cfg.legacy_wait_state_bit ? WAIT_ONE : WAIT_NONE;
            hmask = 8'hFF;
        end else begin
            hmask = high_mask(cfg.high_mask_sel);
            if (in_lower_sector(cpu_req.addr, cfg.sector_limit_field)) begin
                wait_sel = cfg.lower_wait_state_field;
            end else begin
                wait_sel = cfg.upper_wait_state_field;
            end
        end
    end

    assign keeper_on = external_memory_interface_on && cfg.bus_keeper_enable && !cfg.legacy_mode;

    // ****************************************
    // Read data synchroniser
    // ****************************************
    logic [7:0] rd_sync;

    external_memory_interface_pin_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pin_in(muxed_addr_data_bus_in),
        .pin_sync(rd_sync)
    );

    // ****************************************
    // Access sequencer
    // ****************************************
    bus_state_type state_q;
    bus_state_type state_d;
    logic [1:0] wait_cnt_q;
    logic [1:0] wait_len_q;
    logic ext_q;
    logic write_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [1:0] settle_q;
    logic start;
    logic refuse;
    logic done_q;

    // A request while disabled above the SRAM boundary is refused, never aliased.
    // The done cycle is skipped: the CPU still shows the finished request then, and
    // taking it again would run a second, unwanted access.
    assign start = (state_q == ST_IDLE) && cpu_req.req && !done_q &&
        (external_memory_interface_on || !req_is_ext);
    assign refuse = (state_q == ST_IDLE) && cpu_req.req && !done_q && !start;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start) begin
                    state_d = external_memory_interface_on ? ST_ADDR : ST_END;
                end
            end
            ST_ADDR: begin
                state_d = ST_STROBE;
            end
            ST_STROBE: begin
                state_d = (wait_cnt_q == wait_len_q) ? ST_WAIT : ST_STROBE;
            end
            ST_WAIT: begin
                state_d = (settle_q == 2'd3 || !ext_q || write_q) ? ST_END : ST_WAIT;
            end
            ST_END: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Access attributes are captured once, so the pins stay stable for the access.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_q <= 1'b0;
            write_q <= 1'b0;
            addr_q <= ADDR_ZERO;
            wdata_q <= BYTE_ZERO;
            wait_len_q <= WAIT_CNT_RST;
        end else if (start) begin
            ext_q <= req_is_ext && external_memory_interface_on;
            write_q <= cpu_req.write;
            addr_q <= cpu_req.addr;
            wdata_q <= cpu_req.wdata;
            wait_len_q <= wait_sel;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wait_cnt_q <= WAIT_CNT_RST;
        end else if (state_q == ST_STROBE) begin
            wait_cnt_q <= wait_cnt_q + 2'd1;
        end else begin
            wait_cnt_q <= WAIT_CNT_RST;
        end
    end

    // After a read the strobe is released and the synchroniser is allowed to settle.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            settle_q <= 2'd0;
        end else if (state_q == ST_WAIT) begin
            settle_q <= settle_q + 2'd1;
        end else begin
            settle_q <= 2'd0;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic ale_q;
    logic rd_n_q;
    logic wr_n_q;
    logic [7:0] ad_q;
    logic ad_drive_q;
    logic [7:0] ha_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ale_q <= 1'b0;
        end else begin
            // High for the address cycle; falls at the same edge at which ad_q turns to the write data.
            ale_q <= start && external_memory_interface_on;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else begin
            // Strobes only for external accesses; internal ones leave them high.
            // A read keeps its strobe one cycle longer, since the input filter only
            // accepts a byte that it has seen in two samples.
            rd_n_q <= !(ext_q && !write_q &&
                (state_d == ST_STROBE || state_q == ST_STROBE));
            wr_n_q <= !(ext_q && write_q && state_d == ST_STROBE);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ad_q <= BYTE_ZERO;
            ad_drive_q <= 1'b0;
            ha_q <= BYTE_ZERO;
        end else if (start && external_memory_interface_on) begin
            ad_q <= cpu_req.addr[7:0];
            ad_drive_q <= 1'b1;
            ha_q <= cpu_req.addr[15:8];
        end else if (state_q == ST_ADDR) begin
            ad_q <= wdata_q;
            ad_drive_q <= write_q;
        end else if (state_q == ST_END) begin
            ad_drive_q <= 1'b0;
        end
    end

    // With bus_keeper_enable set, the keeper holds the last level whenever the enabled interface releases the bus outside legacy mode.
    assign bus_keeper_en = {8{keeper_on && !ad_drive_q}};

    always_comb begin
        if (external_memory_interface_on) begin
            muxed_addr_data_bus_out = ad_q;
            muxed_addr_data_bus_oe = {8{ad_drive_q}};
            high_address_bus_out = (ha_q & hmask) | (ha_port.port_out & ~hmask);
            high_address_bus_oe = hmask | ha_port.port_dir;
            ale_out = ale_q;
            rd_n_out = rd_n_q;
            wr_n_out = wr_n_q;
            ctl_oe = 3'b111;
        end else begin
            muxed_addr_data_bus_out = ad_port.port_out;
            muxed_addr_data_bus_oe = ad_port.port_dir;
            high_address_bus_out = ha_port.port_out;
            high_address_bus_oe = ha_port.port_dir;
            ale_out = ctl_port.port_out[0];
            rd_n_out = ctl_port.port_out[1];
            wr_n_out = ctl_port.port_out[2];
            // Legacy parts treat these three pins as outputs only.
            ctl_oe = cfg.legacy_mode ? 3'b111 : ctl_port.port_dir[2:0];
        end
    end

    // ****************************************
    // CPU answer
    // ****************************************
    logic fault_q;
    logic [7:0] rdata_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            fault_q <= 1'b0;
            rdata_q <= BYTE_ZERO;
        end else begin
            done_q <= (state_q == ST_END) || refuse;
            fault_q <= refuse;
            if (state_q == ST_WAIT && ext_q && !write_q) begin
                rdata_q <= rd_sync;
            end
        end
    end

    assign cpu_done = done_q;
    assign cpu_fault = fault_q;
    assign cpu_rdata = rdata_q;
    assign cpu_ext = ext_q;

endmodule

// [verification/ext_mem_bus_if_properties.sv]
// Purpose: Port-level checks of the external memory bus interface.
// Assumes: cfg changes only while the interface is idle.
// Notes: Pins that follow software ports are only judged while enabled.
`timescale 1ns/1ps
module ext_mem_bus_if_checker
    import external_memory_interface_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire external_memory_interface_cfg_type cfg,
    input wire cpu_req_type cpu_req,
    input wire logic cpu_done,
    input wire logic cpu_fault,
    input wire logic [7:0] muxed_addr_data_bus_out,
    input wire logic [7:0] high_address_bus_oe,
    input wire logic ale_out,
    input wire logic rd_n_out,
    input wire logic wr_n_out,
    input wire logic [2:0] ctl_oe,
    input wire logic [7:0] bus_keeper_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [1:0] w_exp;
    logic [7:0] hmask;
    logic [2:0] low_q;
    logic en;
    assign en = cfg.ext_mem_enable;
    assign hmask = cfg.legacy_mode ? 8'hFF : 8'hFF >> cfg.high_mask_sel;
    always_comb begin
        if (cfg.legacy_mode) w_exp = {1'b0, cfg.legacy_wait_state_bit};
        else if (cfg.sector_limit_field != 3'h0 &&
                 cpu_req.addr < {cfg.sector_limit_field, 13'h0000})
            w_exp = cfg.lower_wait_state_field;
        else w_exp = cfg.upper_wait_state_field;
    end
    // Counts how long the current strobe has been low.
    always_ff @(posedge clk_sys) begin
        if (!rst_n || (rd_n_out && wr_n_out)) low_q <= 3'h0;
        else low_q <= low_q + 3'h1;
    end
    property p_int_quiet;
        en && cpu_req.req && cpu_req.addr < EXT_BASE |-> rd_n_out && wr_n_out;
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal access");
    property p_refuse;
        cpu_done |-> cpu_fault == (!en && cpu_req.addr >= EXT_BASE);
    endproperty
    a_refuse: assert property (p_refuse) else $error("fault flag wrong at done");
    property p_ale_low;
        en && !(rd_n_out && wr_n_out) |-> !ale_out;
    endproperty
    a_ale_low: assert property (p_ale_low) else $error("latch strobe high in data phase");
    property p_ale_addr;
        en && $fell(ale_out) |-> $past(muxed_addr_data_bus_out) == cpu_req.addr[7:0];
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("low address not valid");
    property p_strobe_len;
        en && $rose(rd_n_out & wr_n_out) |->
            low_q == {1'b0, w_exp} + ($past(rd_n_out) ? 3'h1 : 3'h2);
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe width wrong");
    property p_keeper;
        cfg.legacy_mode && $stable(cfg) |-> bus_keeper_en == 8'h00;
    endproperty
    a_keeper: assert property (p_keeper) else $error("keeper on in legacy mode");
    property p_ctl_out;
        (en || cfg.legacy_mode) && $stable(cfg) |-> ctl_oe == 3'h7;
    endproperty
    a_ctl_out: assert property (p_ctl_out) else $error("control pins not outputs");
    property p_high_oe;
        en && $stable(cfg) |-> (high_address_bus_oe & hmask) == hmask;
    endproperty
    a_high_oe: assert property (p_high_oe) else $error("high address not driven");
    c_fault: cover property (cpu_fault);
    c_long: cover property (!wr_n_out [*4]);
    c_legacy: cover property (cfg.legacy_mode && !rd_n_out);
endmodule
bind ext_mem_bus_if ext_mem_bus_if_checker u_chk (.clk_sys, .rst_n, .cfg, .cpu_req,
    .cpu_done, .cpu_fault, .muxed_addr_data_bus_out, .high_address_bus_oe, .ale_out,
    .rd_n_out, .wr_n_out, .ctl_oe, .bus_keeper_en);

// [verification/sram_model.sv]
// Purpose: External octal latch plus byte-wide static memory.
// Assumes: Writes land on the rising write strobe.
// Notes: A released bus shows the inverse of its last value each cycle.
`timescale 1ns/1ps
module sram_model (
    input wire logic clk_sys,
    input wire logic [7:0] bus,
    input wire logic [7:0] high,
    input wire logic gate,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [7:0] drive
);
    logic [7:0] mem [0:65535];
    logic [7:0] low_q;
    logic [7:0] last_q;
    // The latch is kept as the byte it shows once the gate is low; the memory never
    // looks at it while the gate is high. A clocked copy avoids a race with the bus
    // changing at the same edge at which the gate falls.
    always_ff @(posedge clk_sys) begin
        if (gate) low_q <= bus;
    end
    always @(posedge wr_n) mem[{high, low_q}] <= bus;
    always_ff @(posedge clk_sys) last_q <= drive;
    assign drive = !rd_n ? mem[{high, low_q}] : ~last_q;
endmodule

// [verification/testbench.sv]
// Purpose: Self-checking bench for the external memory bus interface.
// Assumes: Fixed seed, so every run repeats.
// Notes: The disabled test runs last, since port values reach the strobes.
`timescale 1ns/1ps
module testbench
    import external_memory_interface_pkg::*;
;
    logic clk_sys, rst_n, cpu_done, cpu_ext, cpu_fault, ale_out, rd_n_out, wr_n_out;
    logic ext, flt;
    external_memory_interface_cfg_type cfg;
    cpu_req_type cpu_req;
    port_pins_type ad_port, ha_port, ctl_port;
    logic [7:0] cpu_rdata, rd, mdl, bus_keeper_en, muxed_addr_data_bus_in;
    logic [7:0] muxed_addr_data_bus_out, muxed_addr_data_bus_oe;
    logic [7:0] high_address_bus_out, high_address_bus_oe;
    logic [2:0] ctl_oe;
    int n_fail, checks_done;
    ext_mem_bus_if uut (.clk_sys, .rst_n, .cfg, .cpu_req, .cpu_done, .cpu_ext, .cpu_fault,
        .cpu_rdata, .ad_port, .ha_port, .ctl_port, .muxed_addr_data_bus_in,
        .muxed_addr_data_bus_out, .muxed_addr_data_bus_oe, .high_address_bus_out,
        .high_address_bus_oe, .ale_out, .rd_n_out, .wr_n_out, .ctl_oe, .bus_keeper_en);
    sram_model ext_ram (.clk_sys, .bus(muxed_addr_data_bus_in), .high(high_address_bus_out),
        .gate(ale_out), .rd_n(rd_n_out), .wr_n(wr_n_out), .drive(mdl));
    assign muxed_addr_data_bus_in = (muxed_addr_data_bus_oe & muxed_addr_data_bus_out) |
        (~muxed_addr_data_bus_oe & mdl);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [1:0] flags(input logic [15:0] a);
        return {cfg.ext_mem_enable && a >= EXT_BASE, !cfg.ext_mem_enable && a >= EXT_BASE};
    endfunction
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        cpu_req <= '{1'b1, w, a, d};
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (cpu_done !== 1'b1 && n < 60);
        if (n >= 60) chk(8'h00, 8'hFF);
        rd = cpu_rdata;
        ext = cpu_ext;
        flt = cpu_fault;
        chk({6'h00, ext, flt}, {6'h00, flags(a)});
        @(posedge clk_sys);
        cpu_req.req <= 1'b0;
    endtask
    // Writes a random byte, reads it back and compares where it went out.
    task automatic rw(input logic [15:0] a);
        logic [7:0] d;
        d = 8'($urandom);
        acc(1'b1, a, d);
        acc(1'b0, a, 8'h00);
        if (flags(a) == 2'b10) chk(rd, d);
    endtask
    initial begin
        void'($urandom(50851));
        n_fail = 0;
        checks_done = 0;
        rst_n = 1'b0;
        cfg = '0;
        cfg.ext_mem_enable = 1'b1;
        cpu_req = '0;
        ad_port = 16'($urandom);
        ha_port = 16'($urandom);
        ctl_port = '{8'h06, 8'h00};
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            cfg.upper_wait_state_field <= 2'(k);
            cfg.lower_wait_state_field <= 2'(3 - k);
            cfg.sector_limit_field <= 3'(k * 2);
            cfg.high_mask_sel <= 3'(k);
            cfg.bus_keeper_enable <= k[0];
            rw(16'h1100);
            rw({3'(k * 2), 13'h0000});
            rw(16'hFFFF);
            rw(16'h1100 + 16'($urandom_range(16'hEEFF)));
            rw(16'($urandom_range(16'h10FF)));
            @(negedge clk_sys);
            chk(bus_keeper_en, {8{k[0]}});
        end
        $display("wait and sector test done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            cfg <= '{1'b1, 1'b1, k[0], 2'h3, 2'h3, 3'h1, 3'h7, 1'b1};
            rw(16'h1100 + 16'($urandom_range(16'hEEFF)));
            rw(16'h1100);
            @(negedge clk_sys);
            chk(bus_keeper_en, 8'h00);
            chk({5'h00, ctl_oe}, 8'h07);
        end
        $display("legacy test done");
        @(posedge clk_sys);
        cfg <= '0;
        repeat (4) begin
            rw(16'($urandom_range(16'h10FF)));
            rw(16'h1100 + 16'($urandom_range(16'hEEFF)));
            @(posedge clk_sys);
            ad_port <= 16'($urandom);
            ctl_port <= 16'($urandom);
            repeat (2) @(negedge clk_sys);
            chk(muxed_addr_data_bus_oe, ad_port.port_dir);
            chk(muxed_addr_data_bus_out, ad_port.port_out);
            chk(high_address_bus_out, ha_port.port_out);
            chk({5'h00, ctl_oe}, {5'h00, ctl_port.port_dir[2:0]});
        end
        $display("disabled test done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        summarize();
    end
endmodule
